// File: temp_readout_defines.svh
`ifndef TEMP_READOUT_DEFINES_SVH
`define TEMP_READOUT_DEFINES_SVH
// How it works
// - local low byte holds half and quarter
// - local reading steps by quarter degree
// - signed remote high: sign then 64..1
// - unsigned remote high: 128..1 whole degrees
// - remote bytes at 11h,12h,21h,22h
// - remote low byte: half, quarter, eighth
// - remote reading steps by eighth degree
// - high byte read freezes its low byte
// - low byte read returns, then unfreezes
// - each high read refreezes current low
// - maker code readable at FEh
// - die version code readable at FFh
// - local high byte at 10h, signed
// - config bits 1,2 pick remote format
// - missing diode: flag, FFE0h or 8000h

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LOCAL_TEMP_HIGH_ADDR  8'h10
`define REMOTE1_TEMP_HIGH_ADDR 8'h11
`define REMOTE2_TEMP_HIGH_ADDR 8'h12
`define LOCAL_TEMP_LOW_ADDR   8'h20
`define REMOTE1_TEMP_LOW_ADDR 8'h21
`define REMOTE2_TEMP_LOW_ADDR 8'h22
`define MAKER_CODE_ADDR       8'hfe
`define DIE_VERSION_CODE_ADDR 8'hff

// ---------------------------------------------------------------
// field layout and fixed values
// ---------------------------------------------------------------
`define LOCAL_LOW_MASK        8'hc0
`define REMOTE_LOW_MASK       8'he0
`define MISSING_UNSIGNED_VAL  16'hffe0
`define MISSING_SIGNED_VAL    16'h8000
`define CFG_REMOTE1_FMT_BIT   1
`define CFG_REMOTE2_FMT_BIT   2
`define RESET_BYTE            8'h00
`endif

// File: temp_readout_pkg.sv
package temp_readout_pkg;
  typedef enum logic {
    FMT_UNSIGNED,
    FMT_SIGNED
  } format_type;
endpackage

// File: temperature_result_readout.sv
`timescale 1ns/1ps
`include "temp_readout_defines.svh"
module temperature_result_readout #(
  parameter logic [7:0] MAKER_CODE_VAL  = 8'h5a, // arbitrary value
  parameter logic [7:0] DIE_VERSION_VAL = 8'h3c  // arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  config_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        conv_valid_i,
  input  wire logic [15:0] local_conv_i,
  input  wire logic [15:0] remote1_conv_i,
  input  wire logic [15:0] remote2_conv_i,
  input  wire logic        remote1_missing_i,
  input  wire logic        remote2_missing_i,
  output logic             remote1_missing_flag_o,
  output logic             remote2_missing_flag_o
);

  // ---------------------------------------------------------------
  // result storage and freeze state
  // ---------------------------------------------------------------
  logic [7:0] high_r   [3];
  logic [7:0] low_r    [3];
  logic [7:0] frz_r    [3];
  logic [2:0] frozen_r;
  logic [7:0] high_nxt [3];
  logic [7:0] low_nxt  [3];
  logic [7:0] frz_nxt  [3];
  logic [2:0] frozen_nxt;
  logic [7:0] rdata_nxt;
  logic [1:0] miss_r;
  logic [1:0] miss_nxt;
  logic [7:0] high_addr [3];
  logic [7:0] low_addr  [3];
  logic       fmt_sel   [3];
  logic [7:0] low_mask  [3];
  logic [1:0] miss_in;

  assign high_addr[0] = `LOCAL_TEMP_HIGH_ADDR;
  assign high_addr[1] = `REMOTE1_TEMP_HIGH_ADDR;
  assign high_addr[2] = `REMOTE2_TEMP_HIGH_ADDR;
  assign low_addr[0]  = `LOCAL_TEMP_LOW_ADDR;
  assign low_addr[1]  = `REMOTE1_TEMP_LOW_ADDR;
  assign low_addr[2]  = `REMOTE2_TEMP_LOW_ADDR;
  assign low_mask[0]  = `LOCAL_LOW_MASK;
  assign low_mask[1]  = `REMOTE_LOW_MASK;
  assign low_mask[2]  = `REMOTE_LOW_MASK;
  assign fmt_sel[0]   = 1'b1;
  assign fmt_sel[1]   = config_i[`CFG_REMOTE1_FMT_BIT];
  assign fmt_sel[2]   = config_i[`CFG_REMOTE2_FMT_BIT];
  assign miss_in      = {remote2_missing_i, remote1_missing_i};

  // ---------------------------------------------------------------
  // per channel update
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_chan
      logic [15:0] conv_val;
      logic        is_miss;
      temp_readout_pkg::format_type fmt;
      assign fmt = fmt_sel[g] ? temp_readout_pkg::FMT_SIGNED
                              : temp_readout_pkg::FMT_UNSIGNED;
      if (g == 0)
      begin : g_loc
        assign is_miss  = 1'b0;
        assign conv_val = local_conv_i;
      end
      else
      begin : g_rem
        assign is_miss  = miss_in[g-1];
        assign conv_val = (g == 1) ? remote1_conv_i : remote2_conv_i;
      end
      always_comb
      begin
        high_nxt[g]   = high_r[g];
        low_nxt[g]    = low_r[g];
        frz_nxt[g]    = frz_r[g];
        frozen_nxt[g] = frozen_r[g];
        if (conv_valid_i)
        begin
          if (is_miss)
          begin
            if (fmt == temp_readout_pkg::FMT_SIGNED)
            begin
              high_nxt[g] = 8'(`MISSING_SIGNED_VAL >> 8);
              low_nxt[g]  = 8'(`MISSING_SIGNED_VAL);
            end
            else
            begin
              high_nxt[g] = 8'(`MISSING_UNSIGNED_VAL >> 8);
              low_nxt[g]  = 8'(`MISSING_UNSIGNED_VAL);
            end
          end
          else
          begin
            high_nxt[g] = conv_val[15:8];
            low_nxt[g]  = conv_val[7:0] & low_mask[g];
          end
        end
        // reads only; writes never touch this state
        if (reg_rd_i && reg_addr_i == high_addr[g])
        begin
          frozen_nxt[g] = 1'b1;
          frz_nxt[g]    = low_r[g];
        end
        else if (reg_rd_i && reg_addr_i == low_addr[g])
          frozen_nxt[g] = 1'b0;
      end
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
        begin
          high_r[g]   <= `RESET_BYTE;
          low_r[g]    <= `RESET_BYTE;
          frz_r[g]    <= `RESET_BYTE;
          frozen_r[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          high_r[g]   <= high_nxt[g];
          low_r[g]    <= low_nxt[g];
          frz_r[g]    <= frz_nxt[g];
          frozen_r[g] <= frozen_nxt[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data and flags
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = reg_rdata_o;
    miss_nxt  = miss_r;
    if (conv_valid_i)
      miss_nxt = miss_in;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `LOCAL_TEMP_HIGH_ADDR:   rdata_nxt = high_r[0];
        `REMOTE1_TEMP_HIGH_ADDR: rdata_nxt = high_r[1];
        `REMOTE2_TEMP_HIGH_ADDR: rdata_nxt = high_r[2];
        `LOCAL_TEMP_LOW_ADDR:
          rdata_nxt = frozen_r[0] ? frz_r[0] : low_r[0];
        `REMOTE1_TEMP_LOW_ADDR:
          rdata_nxt = frozen_r[1] ? frz_r[1] : low_r[1];
        `REMOTE2_TEMP_LOW_ADDR:
          rdata_nxt = frozen_r[2] ? frz_r[2] : low_r[2];
        `MAKER_CODE_ADDR:        rdata_nxt = MAKER_CODE_VAL;
        `DIE_VERSION_CODE_ADDR:  rdata_nxt = DIE_VERSION_VAL;
        default:                 rdata_nxt = `RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= `RESET_BYTE;
      miss_r      <= 2'b00;
    end
    else if (ce_i)
    begin
      reg_rdata_o <= rdata_nxt;
      miss_r      <= miss_nxt;
    end
  end

  assign remote1_missing_flag_o = miss_r[0];
  assign remote2_missing_flag_o = miss_r[1];

endmodule // temperature_result_readout

// File: readout_props.sv
`timescale 1ns/1ps
module readout_props #(
  parameter logic [7:0] MAKER_CODE_VAL  = 8'h5a,
  parameter logic [7:0] DIE_VERSION_VAL = 8'h3c
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       ce_i,
  input wire logic [7:0] config_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       conv_valid_i,
  input wire logic       remote1_missing_i,
  input wire logic       remote2_missing_i,
  input wire logic       remote1_missing_flag_o,
  input wire logic       remote2_missing_flag_o
);
  // ----------
  // read and flag checks
  // ----------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_s(a);
    ce_i && reg_rd_i && reg_addr_i == a && !conv_valid_i;
  endsequence
  sequence miss1_s;
    ce_i && conv_valid_i && remote1_missing_i && !config_i[1];
  endsequence
  local_low_a: assert property (
    rd_s(8'h20) |=> reg_rdata_o[5:0] == 6'h00) else $error("local low");
  remote_low_a: assert property (
    rd_s(8'h21) |=> reg_rdata_o[4:0] == 5'h00) else $error("remote low");
  maker_code_a: assert property (
    rd_s(8'hfe) |=> reg_rdata_o == MAKER_CODE_VAL) else $error("maker");
  die_code_a: assert property (
    rd_s(8'hff) |=> reg_rdata_o == DIE_VERSION_VAL) else $error("die");
  rdata_hold_a: assert property (
    !(ce_i && reg_rd_i) |=> $stable(reg_rdata_o)) else $error("hold");
  flag_one_a: assert property (
    ce_i && conv_valid_i |=> remote1_missing_flag_o == $past(
    remote1_missing_i)) else $error("flag one");
  flag_two_a: assert property (
    ce_i && conv_valid_i |=> remote2_missing_flag_o == $past(
    remote2_missing_i)) else $error("flag two");
  missing_value_a: assert property (
    miss1_s ##1 rd_s(8'h11) |=> reg_rdata_o == 8'hff) else $error("miss");
endmodule // readout_props
bind temperature_result_readout readout_props #(
  .MAKER_CODE_VAL(MAKER_CODE_VAL), .DIE_VERSION_VAL(DIE_VERSION_VAL)
) i_props (.*);

// File: smbus_host_model.sv
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  // ----------
  // bus cycles
  // ----------
  initial
  begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1 rd_o = 1'b0;
    addr_o = ~a;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1 wr_o = 1'b0;
    wdata_o = ~d;
    @(posedge clk_i);
    #1;
  endtask
endmodule // smbus_host_model

// File: temperature_result_readout_bench.sv
`timescale 1ns/1ps
module temperature_result_readout_bench;
  logic        clk_i, rst_n_i, ce_i, conv_valid_i, reg_rd_i, reg_wr_i;
  logic        remote1_missing_i, remote2_missing_i;
  logic        remote1_missing_flag_o, remote2_missing_flag_o;
  logic [7:0]  config_i, reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [15:0] local_conv_i, remote1_conv_i, remote2_conv_i;
  int          err_count, num_checks;
  temperature_result_readout i_dut (.*);
  smbus_host_model i_host (.clk_i(clk_i), .rdata_i(reg_rdata_o),
    .rd_o(reg_rd_i), .wr_o(reg_wr_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i));
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.read(a, d);
    chk(d, exp);
  endtask
  task automatic conv(input logic [15:0] a, b, input logic m1, m2);
    local_conv_i = 16'h197f;
    remote1_conv_i = a;
    remote2_conv_i = b;
    remote1_missing_i = m1;
    remote2_missing_i = m2;
    conv_valid_i = 1'b1;
    @(posedge clk_i);
    #1 conv_valid_i = 1'b0;
  endtask
  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------
  // sequence
  // ----------
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_n_i, conv_valid_i, remote1_missing_i, remote2_missing_i} = 4'h0;
    {local_conv_i, remote1_conv_i, remote2_conv_i} = 48'h0;
    ce_i = 1'b1;
    config_i = 8'h02;
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    rc(8'hfe, 8'h5a);
    rc(8'hff, 8'h3c);
    rc(8'h30, 8'h00);
    conv(16'he7ff, 16'hc8a0, 1'b0, 1'b0);
    rc(8'h10, 8'h19);
    rc(8'h20, 8'h40);
    rc(8'h11, 8'he7);
    rc(8'h12, 8'hc8);
    rc(8'h22, 8'ha0);
    conv(16'he820, 16'hc840, 1'b0, 1'b0);
    i_host.write(8'h21, 8'hff);
    rc(8'h22, 8'h40);
    rc(8'h21, 8'he0);
    rc(8'h21, 8'h20);
    rc(8'h11, 8'he8);
    conv(16'he860, 16'hc840, 1'b0, 1'b0);
    rc(8'h11, 8'he8);
    conv(16'he8a0, 16'hc840, 1'b0, 1'b0);
    rc(8'h21, 8'h60);
    config_i = 8'h04;
    conv(16'h1234, 16'h5678, 1'b1, 1'b0);
    rc(8'h11, 8'hff);
    rc(8'h21, 8'he0);
    chk({6'h00, remote2_missing_flag_o, remote1_missing_flag_o}, 8'h01);
    conv(16'h1234, 16'h5678, 1'b0, 1'b1);
    rc(8'h12, 8'h80);
    rc(8'h22, 8'h00);
    chk({6'h00, remote2_missing_flag_o, remote1_missing_flag_o}, 8'h02);
    print_verdict();
  end
endmodule // temperature_result_readout_bench
